// *** cip_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cip_top
    import cip_pkg::*;
(
    input  wire logic        ref_clk_i,          // Module clock 10 MHz
    input  wire logic        nrst_i,             // Async reset, active low
    input  wire logic [7:0]  avs_address_i,      // Byte address
    input  wire logic        avs_read_i,         // Read request
    input  wire logic        avs_write_i,        // Write request
    input  wire logic [31:0] avs_writedata_i,    // Write data
    input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes
    output var  logic [31:0] avs_readdata_o,     // Read data
    output var  logic        avs_waitrequest_o,  // Stall
    input  wire logic        can_rx_i,           // Receive pin
    input  wire logic        engine_tx_i,        // Bit from protocol engine
    input  wire logic        bit_tick_i,         // Bit time enable
    input  wire logic        rx_active_i,        // Engine receiving
    input  wire logic        tx_active_i,        // Engine transmitting
    input  wire logic        rx_accept_i,        // Accepted frame at EOF
    input  wire logic [2:0]  tx_done_i,          // Buffer freed pulses
    input  wire logic [7:0]  rx_err_cnt_i,       // Receive error counter
    input  wire logic [8:0]  tx_err_cnt_i,       // Transmit error counter
    input  wire logic        cpu_stop_i,         // CPU in stop mode
    output var  logic        can_tx_pin_o,       // Transmit pin
    output var  logic        online_o,           // Engine may join bus
    output var  logic        core_clk_en_o,      // Protocol clock gate
    output var  logic        reg_clk_en_o,       // Register clock gate
    output var  logic [2:0]  tx_empty_o,         // Buffer empty flags
    output var  logic [95:0] config_o,           // Locked configuration
    output var  logic        irq_wake_o,         // Wake-up request
    output var  logic        irq_err_o,          // Error request
    output var  logic        irq_rx_o,           // Receive request
    output var  logic        irq_tx_o            // Transmit request
);
    cip_mode_t  mode_q;
    cip_slp_t   slp_st;
    cip_slp_t   next_slp;
    logic       unlock;
    logic       sleep_request;
    logic       tx_seen;
    logic       wake_armed;
    logic       rx_bg_full;
    logic [7:0] rflg;
    logic [7:0] rier;
    logic [2:0] tflg;
    logic [2:0] tier;
    logic [7:0] lock_q [LOCK_N];
    logic [7:0] set_r;
    logic [7:0] clr_r;
    logic [2:0] clr_t;
    logic [31:0] rd_mux;
    logic       commit_wr;
    logic       regs_ok;
    logic       online;
    logic       copy_fg;
    logic       ovr_ev;
    logic       activity;
    logic       idle_ok;
    logic       resync;
    logic       wr_mcr0;
    logic [7:0] wbyte;
    logic [7:0] lock_ofs;

    cip_bus_mon u_mon (
        .ref_clk_i  (ref_clk_i),
        .nrst_i     (nrst_i),
        .can_rx_i   (can_rx_i),
        .bit_tick_i (bit_tick_i),
        .resync_i   (resync),
        .activity_o (activity),
        .idle_ok_o  (idle_ok)
    );

    // Bus slave: one wait cycle, write commits when waitrequest is low
    assign regs_ok   = (mode_q != CIP_PWRDN);
    assign commit_wr = avs_write_i & ~avs_waitrequest_o & regs_ok
                     & avs_byteenable_i[0];
    assign wbyte     = avs_writedata_i[7:0];
    assign wr_mcr0   = commit_wr && (avs_address_i == OFS_MCR0);
    assign lock_ofs  = avs_address_i - OFS_LOCK0;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_waitrequest_o <= 1'h1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'h0;
            avs_readdata_o    <= regs_ok ? rd_mux : 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= 1'h1;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            OFS_MCR0: begin
                rd_mux[B_UNLOCK] = unlock;
                rd_mux[B_SLEEP_REQUEST]  = sleep_request;
                rd_mux[B_SLEEP_ACKNOWLEDGE]  = (slp_st == SLP_ASLEEP);
                rd_mux[B_SYNCED] = online;
            end
            OFS_RFLG:   rd_mux[7:0] = rflg;
            OFS_RIER:   rd_mux[7:0] = rier;
            OFS_TFLG:   rd_mux[2:0] = tflg;
            OFS_TIER:   rd_mux[2:0] = tier;
            OFS_ERRCNT: rd_mux[16:0] = {tx_err_cnt_i, rx_err_cnt_i};
            default: begin
                if (avs_address_i >= OFS_LOCK0 && avs_address_i < OFS_RFLG
                    && avs_address_i[1:0] == 2'h0) begin
                    rd_mux[7:0] = lock_q[lock_ofs[5:2]];
                end
            end
        endcase
    end

    // Locked set: control 1, timing 0-1, acceptance control, codes, masks
    genvar gi;
    generate
        for (gi = 0; gi < LOCK_N; gi++) begin : g_lock
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    lock_q[gi] <= RST_BYTE;
                end else if (commit_wr && unlock
                             && avs_address_i == OFS_LOCK0
                                + 8'(4 * gi)) begin
                    lock_q[gi] <= wbyte;
                end
            end
            assign config_o[8*gi +: 8] = lock_q[gi];
        end
    endgenerate

    // Enables are plain read/write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rier <= RST_BYTE;
            tier <= 3'h0;
        end else if (commit_wr && avs_address_i == OFS_RIER) begin
            rier <= wbyte;
        end else if (commit_wr && avs_address_i == OFS_TIER) begin
            tier <= wbyte[2:0];
        end
    end

    // Mode control bits
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            unlock        <= RST_UNLOCK;
            sleep_request <= 1'h0;
        end else begin
            if (wr_mcr0) begin
                unlock <= wbyte[B_UNLOCK];
            end
            if (wr_mcr0 && (wbyte[B_SLEEP_REQUEST] || slp_st == SLP_ASLEEP)) begin
                sleep_request <= wbyte[B_SLEEP_REQUEST];
            end else if (slp_st == SLP_ASLEEP && activity) begin
                sleep_request <= 1'h0;
            end
        end
    end

    // Sleep sequencing
    always_comb begin
        next_slp = slp_st;
        case (slp_st)
            SLP_AWAKE: begin
                if (unlock) begin
                    next_slp = SLP_RESYNC;
                end else if (sleep_request) begin
                    next_slp = SLP_PENDING;
                end
            end
            SLP_PENDING: begin
                if (unlock) begin
                    next_slp = SLP_RESYNC;
                end else if (!rx_active_i && !tx_active_i
                             && (!tx_seen || &tflg)) begin
                    next_slp = SLP_ASLEEP;
                end
            end
            SLP_ASLEEP: begin
                if (activity || !sleep_request || unlock) begin
                    next_slp = SLP_RESYNC;
                end
            end
            SLP_RESYNC: begin
                if (idle_ok && !unlock) begin
                    next_slp = SLP_AWAKE;
                end
            end
            default: next_slp = SLP_RESYNC;
        endcase
    end

    assign resync = (slp_st != SLP_RESYNC) && (next_slp == SLP_RESYNC);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slp_st <= SLP_RESYNC;
        end else if (regs_ok) begin
            slp_st <= next_slp;
        end
    end

    // Once a frame goes out during the request, drain the whole queue
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_seen <= 1'h0;
        end else if (slp_st != SLP_PENDING) begin
            tx_seen <= 1'h0;
        end else if (tx_active_i) begin
            tx_seen <= 1'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q <= CIP_NORMAL;
        end else if (cpu_stop_i) begin
            mode_q <= CIP_PWRDN;
        end else if (slp_st == SLP_ASLEEP && !unlock) begin
            mode_q <= CIP_SLEEP;
        end else if (unlock) begin
            mode_q <= CIP_SOFTRST;
        end else begin
            mode_q <= CIP_NORMAL;
        end
    end

    assign online = (mode_q == CIP_NORMAL)
                  && (slp_st == SLP_AWAKE || slp_st == SLP_PENDING);

    // Receive buffers: foreground is the full flag, background held here
    assign copy_fg = online && !rflg[F_RXF] && rx_bg_full;
    assign ovr_ev  = online && rx_accept_i && rflg[F_RXF] && rx_bg_full;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_bg_full <= 1'h0;
        end else if (copy_fg) begin
            rx_bg_full <= 1'h0;
        end else if (online && rx_accept_i && rflg[F_RXF]) begin
            rx_bg_full <= 1'h1;
        end
    end

    // Level conditions re-set each cycle, so a clear cannot win early
    always_comb begin
        set_r          = 8'h00;
        set_r[F_RXF]   = copy_fg
                       || (online && rx_accept_i && !rflg[F_RXF]);
        set_r[F_OVR]   = ovr_ev;
        set_r[F_BOFF]  = tx_err_cnt_i > BOFF_LIMIT;
        set_r[F_TXPAS] = tx_err_cnt_i > PASS_LIMIT;
        set_r[F_RXPAS] = {1'h0, rx_err_cnt_i} > PASS_LIMIT;
        set_r[F_TXWRN] = tx_err_cnt_i >= WARN_LIMIT;
        set_r[F_RXWRN] = {1'h0, rx_err_cnt_i} >= WARN_LIMIT;
        set_r[F_WAKE]  = activity && (slp_st == SLP_ASLEEP
                       || mode_q == CIP_PWRDN);
    end

    assign clr_r = (commit_wr && avs_address_i == OFS_RFLG)
                 ? wbyte : 8'h00;
    assign clr_t = (commit_wr && avs_address_i == OFS_TFLG)
                 ? wbyte[2:0] : 3'h0;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rflg <= RST_BYTE;
            tflg <= RST_TXE;
        end else begin
            rflg <= (rflg & ~clr_r) | set_r;
            tflg <= (tflg & ~clr_t) | tx_done_i;
        end
    end

    // Wake irq only counts if acknowledge was high at the wake event
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_armed <= 1'h0;
        end else if (set_r[F_WAKE]) begin
            wake_armed <= (slp_st == SLP_ASLEEP);
        end else if (!rflg[F_WAKE]) begin
            wake_armed <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_wake_o <= 1'h0;
            irq_err_o  <= 1'h0;
            irq_rx_o   <= 1'h0;
            irq_tx_o   <= 1'h0;
        end else begin
            irq_wake_o <= rflg[F_WAKE] & rier[F_WAKE] & wake_armed;
            irq_err_o  <= |(rflg[F_RXWRN:F_OVR]
                          & rier[F_RXWRN:F_OVR]);
            irq_rx_o   <= rflg[F_RXF] & rier[F_RXF];
            irq_tx_o   <= |(tflg & tier);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            can_tx_pin_o  <= 1'h1;
            online_o      <= 1'h0;
            core_clk_en_o <= 1'h0;
            reg_clk_en_o  <= 1'h1;
            tx_empty_o    <= RST_TXE;
        end else begin
            can_tx_pin_o  <= online ? engine_tx_i : 1'h1;
            online_o      <= online;
            core_clk_en_o <= (mode_q == CIP_NORMAL);
            reg_clk_en_o  <= (mode_q != CIP_PWRDN);
            tx_empty_o    <= tflg;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_TX_RECESSIVE: assert property (
        mode_q != CIP_NORMAL |=> can_tx_pin_o)
        else $error("tx pin not recessive in low power mode");
    AST_ERR_IRQ: assert property (
        |(rflg[F_RXWRN:F_OVR] & rier[F_RXWRN:F_OVR]) |=> irq_err_o)
        else $error("error irq missing while enabled flag set");
    AST_RX_FULL: assert property (
        online && rx_accept_i |=> rflg[F_RXF])
        else $error("accepted frame did not set rx full");
    AST_OVERRUN: assert property (
        ovr_ev |=> rflg[F_OVR] && rx_bg_full && rflg[F_RXF])
        else $error("overrun not flagged or buffers changed");
    AST_WARN: assert property (
        {1'h0, rx_err_cnt_i} >= WARN_LIMIT |=> rflg[F_RXWRN])
        else $error("rx warning flag not set at 96");
    AST_BUS_OFF: assert property (
        tx_err_cnt_i > BOFF_LIMIT && rier[F_BOFF] |=> ##1 irq_err_o)
        else $error("bus off did not raise error irq");
    AST_PASSIVE: assert property (
        tx_err_cnt_i > PASS_LIMIT |=> rflg[F_TXPAS])
        else $error("tx passive flag not set above 127");
    AST_LOCK: assert property (
        commit_wr && !unlock |=> $stable(config_o))
        else $error("locked register changed without soft reset");
    AST_PWRDN: assert property (
        cpu_stop_i ##1 cpu_stop_i |=> !reg_clk_en_o && !core_clk_en_o)
        else $error("clocks not stopped in power-down");
    AST_SLEEP_REQUEST_HOLD: assert property (
        wr_mcr0 && sleep_request && slp_st != SLP_ASLEEP
        |=> sleep_request)
        else $error("sleep request cleared before acknowledge");
    AST_TXE: assert property (
        tx_done_i[0] && tier[0] |=> tflg[0] ##1 irq_tx_o)
        else $error("tx empty flag or irq missing");

    COV_SLEEP: cover property (
        slp_st == SLP_PENDING ##[1:50] slp_st == SLP_ASLEEP);
    COV_OVERRUN: cover property (ovr_ev);
    COV_WAKE_IRQ: cover property (irq_wake_o);
endmodule
`default_nettype wire

// *** cip_pkg.sv ***
// Function
// - Eleven flag sources, each with an enable, feed four interrupt outputs.
// - Each transmit buffer that becomes empty sets its empty flag.
// - Accepted frame at end-of-frame fills foreground buffer and sets rx full.
// - Bus activity in sleep or power-down sets wake flag; irq needs ack.
// - Error counters reaching 96 set the matching warning flags.
// - Error counters above 127 set the matching passive flags.
// - Transmit error counter above 255 sets bus-off flag for error irq.
// - Receive overrun sets the overrun flag, an error irq source.
// - Both buffers full plus another accepted frame is overrun; frame dropped.
// - Each irq except wake stays high while any enabled flag of it is set.
// - Writing one clears a flag; writing zero leaves it.
// - Clear has no effect while the setting condition persists.
// - Error counters cannot be altered by any register access.
// - Configuration registers accept writes only while soft reset is set.
// - Transmit pin is recessive in sleep, soft reset and power-down.
// - Sleep and soft reset stop core clocks; power-down stops all.
// - CPU stop gives power-down; else ack and unlock bits pick the mode.
// - Sleep entered when idle, after reception, or once transmit queue empty.
// - Sleep acknowledge stays one throughout sleep; software uses it.
// - Sleep left on bus activity, request cleared, or soft reset set.
// - Clearing sleep request before acknowledge is ignored.
// - After wake, wait 11 recessive bits before joining traffic.
package cip_pkg;
    localparam logic [7:0] OFS_MCR0    = 8'h00;
    localparam logic [7:0] OFS_LOCK0   = 8'h04;
    localparam logic [7:0] OFS_RFLG    = 8'h34;
    localparam logic [7:0] OFS_RIER    = 8'h38;
    localparam logic [7:0] OFS_TFLG    = 8'h3C;
    localparam logic [7:0] OFS_TIER    = 8'h40;
    localparam logic [7:0] OFS_ERRCNT  = 8'h44;
    localparam int         LOCK_N      = 12;
    localparam int         B_UNLOCK    = 0;
    localparam int         B_SLEEP_REQUEST     = 1;
    localparam int         B_SLEEP_ACKNOWLEDGE     = 2;
    localparam int         B_SYNCED    = 3;
    localparam int         F_RXF       = 0;
    localparam int         F_OVR       = 1;
    localparam int         F_BOFF      = 2;
    localparam int         F_TXPAS     = 3;
    localparam int         F_RXPAS     = 4;
    localparam int         F_TXWRN     = 5;
    localparam int         F_RXWRN     = 6;
    localparam int         F_WAKE      = 7;
    localparam logic [8:0] WARN_LIMIT  = 9'h060;
    localparam logic [8:0] PASS_LIMIT  = 9'h07F;
    localparam logic [8:0] BOFF_LIMIT  = 9'h0FF;
    localparam logic [3:0] RECESS_RUN  = 4'hB;
    localparam logic       RST_UNLOCK  = 1'h1;
    localparam logic [2:0] RST_TXE     = 3'h7;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    typedef enum logic [1:0] {
        CIP_NORMAL  = 2'h0,
        CIP_SLEEP   = 2'h1,
        CIP_SOFTRST = 2'h2,
        CIP_PWRDN   = 2'h3
    } cip_mode_t;
    typedef enum logic [1:0] {
        SLP_AWAKE   = 2'h0,
        SLP_PENDING = 2'h1,
        SLP_ASLEEP  = 2'h2,
        SLP_RESYNC  = 2'h3
    } cip_slp_t;
endpackage

// *** cip_bus_mon.sv ***
`timescale 1ns/1ps
`default_nettype none
module cip_bus_mon
    import cip_pkg::*;
(
    input  wire logic ref_clk_i,   // Module clock
    input  wire logic nrst_i,      // Async reset, active low
    input  wire logic can_rx_i,    // Receive pin, asynchronous
    input  wire logic bit_tick_i,  // One pulse per bit time
    input  wire logic resync_i,    // Restart recessive run count
    output var  logic activity_o,  // Recessive to dominant edge
    output var  logic idle_ok_o    // Eleven recessive bits seen
);
    logic       rx_meta;
    logic       rx_sync;
    logic       rx_prev;
    logic [3:0] run;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_meta <= 1'h1;
            rx_sync <= 1'h1;
            rx_prev <= 1'h1;
        end else begin
            rx_meta <= can_rx_i;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            activity_o <= 1'h0;
        end else begin
            activity_o <= rx_prev & ~rx_sync;
        end
    end

    // Any dominant level restarts the run; the waking frame is lost
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run       <= 4'h0;
            idle_ok_o <= 1'h0;
        end else if (resync_i || !rx_sync) begin
            run       <= 4'h0;
            idle_ok_o <= 1'h0;
        end else if (bit_tick_i && !idle_ok_o) begin
            run       <= run + 4'h1;
            idle_ok_o <= (run + 4'h1) == RECESS_RUN;
        end
    end
endmodule
`default_nettype wire

// *** cip_can_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bus and bit-time side; recessive bus reads 1 by pull-up
module cip_can_model #(
    parameter int TICK_N = 4
) (
    input  wire logic ref_clk_i,  // Module clock
    input  wire logic nrst_i,     // Async reset, active low
    input  wire logic act_i,      // Start a dominant burst
    output var  logic can_rx_o,   // Bus level, 1 = recessive
    output var  logic bit_tick_o  // One pulse per bit
);
    logic [3:0] cnt;
    logic [4:0] dom;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 4'h0;
            bit_tick_o <= 1'b0;
        end else begin
            bit_tick_o <= (cnt == 4'(TICK_N - 1));
            cnt <= (cnt == 4'(TICK_N - 1)) ? 4'h0 : cnt + 4'h1;
        end
    end
    // Short start burst, then bus idles recessive
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dom <= 5'h0;
        end else begin
            dom <= act_i ? 5'hC : (dom != 5'h0 ? dom - 5'h1 : dom);
        end
    end
    assign can_rx_o = (dom == 5'h0);
endmodule
`default_nettype wire

// *** tb_can_irq_protect_lowpower.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_can_irq_protect_lowpower;
    import cip_pkg::*;
    logic ref_clk_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic [7:0] avs_address_i = 0, rx_err_cnt_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, rd, seed = 40376;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic avs_waitrequest_o, can_rx, tick, act = 0, engine_tx_i = 1;
    logic rx_accept_i = 0, cpu_stop_i = 0, can_tx_pin_o, online_o;
    logic rx_active_i = 0, tx_active_i = 0;
    logic core_clk_en_o, reg_clk_en_o, irq_wake_o, irq_err_o, irq_rx_o;
    logic irq_tx_o, prev;
    logic [2:0] tx_done_i = 0, tx_empty_o;
    logic [8:0] tx_err_cnt_i = 0;
    logic [95:0] config_o, cfg;
    int err_count = 0, num_checks = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    cip_can_model #(.TICK_N(4)) bus (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .act_i(act), .can_rx_o(can_rx), .bit_tick_o(tick));
    cip_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .can_rx_i(can_rx),
        .engine_tx_i(engine_tx_i), .bit_tick_i(tick),
        .rx_active_i(rx_active_i), .tx_active_i(tx_active_i),
        .rx_accept_i(rx_accept_i), .tx_done_i(tx_done_i),
        .rx_err_cnt_i(rx_err_cnt_i), .tx_err_cnt_i(tx_err_cnt_i),
        .cpu_stop_i(cpu_stop_i), .can_tx_pin_o(can_tx_pin_o),
        .online_o(online_o), .core_clk_en_o(core_clk_en_o),
        .reg_clk_en_o(reg_clk_en_o), .tx_empty_o(tx_empty_o),
        .config_o(config_o), .irq_wake_o(irq_wake_o), .irq_err_o(irq_err_o),
        .irq_rx_o(irq_rx_o), .irq_tx_o(irq_tx_o));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] eflg(logic [7:0] r, logic [8:0] t);
        return {1'b0, r >= 8'd96, t >= 9'd96, r > 8'd127, t > 9'd127,
                t > 9'd255, 2'b00};
    endfunction
    task automatic chk(input logic [95:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Request held until waitrequest is sampled low
    // No local limit: only the watchdog may end a stalled transfer
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= we;
        avs_read_i <= !we;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic accept();
        @(posedge ref_clk_i);
        rx_accept_i <= 1'b1;
        @(posedge ref_clk_i);
        rx_accept_i <= 1'b0;
    endtask
    initial begin
        #(100 * 30000);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        w(1);
        chk({tx_empty_o, can_tx_pin_o, online_o}, 5'h1E,
            "reset pins");
        xfer(0, OFS_MCR0, 0);
        chk(rd[0], 1, "unlock after reset");
        for (int i = 0; i < 2 * LOCK_N; i++) begin
            if (i == LOCK_N) xfer(1, OFS_MCR0, 8'h00);
            cfg = config_o;
            if (i < LOCK_N) cfg[8*(i%LOCK_N) +: 8] = 8'(rnd());
            // Locked pass writes the inverse, so a leak would show
            xfer(1, 8'(OFS_LOCK0 + 4 * (i % LOCK_N)),
                 cfg[8*(i%LOCK_N) +: 8] ^ (i < LOCK_N ? 8'h00 : 8'hFF));
            w(1);
            chk(config_o, cfg, "lock");
        end
        $display("END lock");
        for (int n = 0; n < 100 && online_o !== 1'b1; n++) w(1);
        chk(online_o, 1, "online after recessive run");
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk_i);
            prev = engine_tx_i;
            engine_tx_i <= 1'(rnd());
            w(0);
            if (i > 0) chk(can_tx_pin_o, prev, "pin follows engine");
        end
        xfer(1, OFS_RIER, 8'hFF);
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk_i);
            rx_err_cnt_i <= i < 4 ? 8'(95 + i % 2 * 33) : 8'(rnd());
            tx_err_cnt_i <= i < 4 ? 9'(255 + i) : 9'(rnd());
            w(3);
            xfer(1, OFS_RFLG, 8'h7C);
            xfer(1, OFS_ERRCNT, 8'hAA);
            w(2);
            xfer(0, OFS_RFLG, 0);
            chk(rd[7:0] & 8'h7C,
                eflg(rx_err_cnt_i, tx_err_cnt_i), "err flags");
            w(1);
            chk(irq_err_o,
                |eflg(rx_err_cnt_i, tx_err_cnt_i), "err irq");
            xfer(0, OFS_ERRCNT, 0);
            chk(rd[16:0], {tx_err_cnt_i, rx_err_cnt_i}, "counters ro");
        end
        @(posedge ref_clk_i);
        rx_err_cnt_i <= 8'h0;
        tx_err_cnt_i <= 9'h0;
        w(2);
        xfer(1, OFS_RFLG, 8'h7C);
        xfer(1, OFS_RFLG, 8'h00);
        w(2);
        chk({irq_err_o, irq_rx_o}, 0, "clear by one");
        $display("END errors");
        accept();
        w(2);
        chk(irq_rx_o, 1, "rx irq");
        accept();
        accept();
        w(3);
        xfer(0, OFS_RFLG, 0);
        chk(rd[1:0], 2'h3, "overrun flag");
        chk(irq_err_o, 1, "overrun irq");
        xfer(1, OFS_RFLG, 8'h03);
        w(2);
        xfer(0, OFS_RFLG, 0);
        chk(rd[1:0], 2'h1, "background copied");
        xfer(1, OFS_RFLG, 8'h01);
        w(2);
        chk(irq_rx_o, 0, "rx released");
        $display("END receive");
        xfer(1, OFS_TIER, 8'h07);
        w(1);
        chk(irq_tx_o, 1, "tx irq empty");
        xfer(1, OFS_TFLG, 8'h07);
        w(2);
        chk({tx_empty_o, irq_tx_o}, 0, "tx cleared");
        @(posedge ref_clk_i);
        tx_done_i <= 3'h2;
        @(posedge ref_clk_i);
        tx_done_i <= 3'h0;
        w(2);
        chk({tx_empty_o, irq_tx_o}, 4'h5, "buffer freed");
        xfer(1, OFS_TIER, 8'h01);
        w(2);
        chk(irq_tx_o, 0, "tx masked");
        @(posedge ref_clk_i);
        tx_done_i <= 3'h1;
        @(posedge ref_clk_i);
        tx_done_i <= 3'h0;
        w(2);
        chk({tx_empty_o, irq_tx_o}, 4'h7, "buffer 0 freed");
        $display("END transmit");
        @(posedge ref_clk_i);
        engine_tx_i <= 1'b0;
        rx_active_i <= 1'b1;
        tx_active_i <= 1'b1;
        xfer(1, OFS_MCR0, 8'h02);
        w(3);
        @(posedge ref_clk_i);
        rx_active_i <= 1'b0;
        tx_active_i <= 1'b0;
        w(3);
        xfer(0, OFS_MCR0, 0);
        chk(rd[2:1], 2'h1, "sleep waits for queue");
        @(posedge ref_clk_i);
        tx_done_i <= 3'h4;
        @(posedge ref_clk_i);
        tx_done_i <= 3'h0;
        w(3);
        xfer(0, OFS_MCR0, 0);
        chk(rd[2:1], 2'h3, "sleep ack");
        chk({can_tx_pin_o, core_clk_en_o, reg_clk_en_o}, 3'h5,
            "sleep pins");
        @(posedge ref_clk_i);
        act <= 1'b1;
        @(posedge ref_clk_i);
        act <= 1'b0;
        w(8);
        chk(irq_wake_o, 1, "wake irq");
        xfer(0, OFS_MCR0, 0);
        chk(rd[2:1], 2'h0, "woken");
        xfer(1, OFS_RFLG, 8'h80);
        $display("END sleep");
        @(posedge ref_clk_i);
        cpu_stop_i <= 1'b1;
        w(3);
        chk({can_tx_pin_o, reg_clk_en_o, core_clk_en_o}, 3'h4,
            "power down");
        @(posedge ref_clk_i);
        act <= 1'b1;
        @(posedge ref_clk_i);
        act <= 1'b0;
        w(8);
        chk(irq_wake_o, 0, "no wake irq without ack");
        @(posedge ref_clk_i);
        cpu_stop_i <= 1'b0;
        w(2);
        xfer(0, OFS_RFLG, 0);
        chk(rd[7], 1, "wake flag in power-down");
        $display("END powerdown");
        complete_run();
    end
endmodule
`default_nettype wire
